// ### hdl/extline_pkg.sv
// Constants shared by the external line pending and port select block
package extline_pkg;
  localparam int NUM_LINES = 19;
  localparam int FIRST_W   = 9;
  localparam int SECOND_W  = 9;
  localparam int THIRD_W   = 5;
  localparam int UPPER_W   = 10;
  localparam int MUX_LINES = 9;

  localparam logic [7:0] OFF_RISE_CFG  = 8'h00;
  localparam logic [7:0] OFF_FALL_CFG  = 8'h04;
  localparam logic [7:0] OFF_SOFT_TRIG = 8'h08;
  localparam logic [7:0] OFF_PENDING   = 8'h0c;
  localparam logic [7:0] OFF_SEL_0_3   = 8'h60;
  localparam logic [7:0] OFF_SEL_4_7   = 8'h64;
  localparam logic [7:0] OFF_SEL_8     = 8'h68;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h90;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h94;

  localparam int L0_SEL_LSB = 0;
  localparam int L1_SEL_LSB = 8;
  localparam int L2_SEL_LSB = 16;
  localparam int L3_SEL_LSB = 24;
  localparam int L4_SEL_LSB = 0;
  localparam int L5_SEL_BIT = 8;
  localparam int L6_SEL_BIT = 16;
  localparam int L7_SEL_BIT = 19;
  localparam int L8_SEL_BIT = 0;

  localparam logic [31:0] SEL_0_3_MASK = 32'h0303_0303;
  localparam logic [31:0] SEL_4_7_MASK = 32'h0009_0103;
  localparam logic [31:0] SEL_8_MASK   = 32'h0000_0001;
  localparam logic [31:0] SEL_RESET    = 32'h0000_0000;

  localparam logic [1:0] SRC_FIRST  = 2'h0;
  localparam logic [1:0] SRC_SECOND = 2'h1;
  localparam logic [1:0] SRC_THIRD  = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [NUM_LINES-1:0] LINES_RESET = 19'h0;
endpackage

// ### hdl/pin_sync.sv
// Two-stage synchroniser for a vector of pin levels
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_next;

  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
  end

  always_comb begin
    stage1_next = pin_in;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign pin_sync_out = stage2_reg;
endmodule

// ### hdl/line_edge.sv
// Rising and falling edge detector for synchronised line levels
module line_edge #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] prev_next;

  initial begin
    if (WIDTH < 1) $error("line_edge: WIDTH must be at least 1");
  end

  always_comb begin
    prev_next = level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;
endmodule

// ### hdl/ext_line_pending_and_port_select.sv
// External line controller: pending flags, port select and AXI4-Lite registers
module ext_line_pending_and_port_select #(
  parameter int ADDR_W = 8
) (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  input  wire logic [ADDR_W-1:0]                    s_axi_awaddr,
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]                    s_axi_araddr,
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  input  wire logic [extline_pkg::FIRST_W-1:0]      first_gpio_port,
  input  wire logic [extline_pkg::SECOND_W-1:0]     second_gpio_port,
  input  wire logic [extline_pkg::THIRD_W-1:0]      third_gpio_port,
  input  wire logic [extline_pkg::UPPER_W-1:0]      upper_line_in,
  output logic [extline_pkg::NUM_LINES-1:0]         line_request,
  output logic                                      irq
);
  localparam int NL = extline_pkg::NUM_LINES;

  initial begin
    if (ADDR_W < 8) $error("ext_line: ADDR_W must be at least 8");
  end

  // Byte-enable expansion, used for every writable register
  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Three-way source pick; the reserved code gives a quiet low line
  function automatic logic pick3(input logic [1:0] sel, input logic a,
                                 input logic b, input logic c);
    logic r;
    case (sel)
      extline_pkg::SRC_FIRST: begin
        r = a;
      end
      extline_pkg::SRC_SECOND: begin
        r = b;
      end
      extline_pkg::SRC_THIRD: begin
        r = c;
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
    return {a[7:2], 2'b00};
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == extline_pkg::OFF_RISE_CFG) || (a == extline_pkg::OFF_FALL_CFG) ||
           (a == extline_pkg::OFF_SOFT_TRIG) || (a == extline_pkg::OFF_PENDING) ||
           (a == extline_pkg::OFF_SEL_0_3) || (a == extline_pkg::OFF_SEL_4_7) ||
           (a == extline_pkg::OFF_SEL_8) || (a == extline_pkg::OFF_IRQ_STAT) ||
           (a == extline_pkg::OFF_IRQ_MASK);
  endfunction

  // Pin synchronisers and line source selection
  logic [extline_pkg::FIRST_W-1:0]  first_s;
  logic [extline_pkg::SECOND_W-1:0] second_s;
  logic [extline_pkg::THIRD_W-1:0]  third_s;
  logic [extline_pkg::UPPER_W-1:0]  upper_s;
  logic [NL-1:0]                    line_level;
  logic [NL-1:0]                    line_rise;
  logic [NL-1:0]                    line_fall;

  pin_sync #(.WIDTH(extline_pkg::FIRST_W)) u_sync_first (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .pin_in       (first_gpio_port),
    .pin_sync_out (first_s)
  );
  pin_sync #(.WIDTH(extline_pkg::SECOND_W)) u_sync_second (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .pin_in       (second_gpio_port),
    .pin_sync_out (second_s)
  );
  pin_sync #(.WIDTH(extline_pkg::THIRD_W)) u_sync_third (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .pin_in       (third_gpio_port),
    .pin_sync_out (third_s)
  );
  pin_sync #(.WIDTH(extline_pkg::UPPER_W)) u_sync_upper (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .pin_in       (upper_line_in),
    .pin_sync_out (upper_s)
  );

  logic [31:0] sel_0_3_reg;
  logic [31:0] sel_4_7_reg;
  logic [31:0] sel_8_reg;

  always_comb begin
    line_level[0] = pick3(sel_0_3_reg[extline_pkg::L0_SEL_LSB +: 2],
                          first_s[0], second_s[0], third_s[0]);
    line_level[1] = pick3(sel_0_3_reg[extline_pkg::L1_SEL_LSB +: 2],
                          first_s[1], second_s[1], third_s[1]);
    line_level[2] = pick3(sel_0_3_reg[extline_pkg::L2_SEL_LSB +: 2],
                          first_s[2], second_s[2], third_s[2]);
    line_level[3] = pick3(sel_0_3_reg[extline_pkg::L3_SEL_LSB +: 2],
                          first_s[3], second_s[3], third_s[3]);
    line_level[4] = pick3(sel_4_7_reg[extline_pkg::L4_SEL_LSB +: 2],
                          first_s[4], second_s[4], third_s[4]);
    line_level[5] = sel_4_7_reg[extline_pkg::L5_SEL_BIT] ? second_s[5] : first_s[5];
    line_level[6] = sel_4_7_reg[extline_pkg::L6_SEL_BIT] ? second_s[6] : first_s[6];
    line_level[7] = sel_4_7_reg[extline_pkg::L7_SEL_BIT] ? second_s[7] : first_s[7];
    line_level[8] = sel_8_reg[extline_pkg::L8_SEL_BIT] ? second_s[8] : first_s[8];
    line_level[NL-1:extline_pkg::MUX_LINES] = upper_s;
  end

  line_edge #(.WIDTH(NL)) u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (line_level),
    .rise    (line_rise),
    .fall    (line_fall)
  );

  // AXI4-Lite handshake state
  logic              aw_held_reg, aw_held_next;
  logic              w_held_reg, w_held_next;
  logic [7:0]        aw_addr_reg, aw_addr_next;
  logic [31:0]       w_data_reg, w_data_next;
  logic [3:0]        w_strb_reg, w_strb_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              rvalid_reg, rvalid_next;
  logic [1:0]        rresp_reg, rresp_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic              aw_take, w_take, ar_take, wr_fire;
  logic [7:0]        ar_word;
  logic [31:0]       wmask;
  logic [31:0]       merged;
  logic              awready_reg, awready_next, wready_reg, wready_next;
  logic              arready_reg, arready_next;

  // Line registers
  logic [NL-1:0]     rise_cfg_reg, rise_cfg_next;
  logic [NL-1:0]     fall_cfg_reg, fall_cfg_next;
  logic [NL-1:0]     soft_reg, soft_next;
  logic [NL-1:0]     pending_reg, pending_next;
  logic [NL-1:0]     irq_stat_reg, irq_stat_next;
  logic [NL-1:0]     irq_mask_reg, irq_mask_next;
  logic [31:0]       sel_0_3_next, sel_4_7_next, sel_8_next;
  logic              irq_reg, irq_next;
  logic [NL-1:0]     pend_set, pend_clr, fall_block;

  always_comb begin
    aw_take = s_axi_awvalid && !aw_held_reg && !bvalid_reg;
    w_take  = s_axi_wvalid && !w_held_reg && !bvalid_reg;
    ar_take = s_axi_arvalid && !rvalid_reg;
    wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    ar_word = word_addr(s_axi_araddr);
    wmask   = s_axi_wdata_mask(w_data_reg, w_strb_reg);
  end

  function automatic logic [31:0] s_axi_wdata_mask(input logic [31:0] d,
                                                   input logic [3:0] s);
    return d & strobe_mask(s);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] keep);
    return ((old & ~strobe_mask(s)) | (d & strobe_mask(s))) & keep;
  endfunction

  // Bus channel next state
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (aw_take) begin
      aw_held_next = 1'b1;
      aw_addr_next = word_addr(s_axi_awaddr);
    end
    if (w_take) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = is_mapped(aw_addr_reg) ? extline_pkg::RESP_OKAY
                                            : extline_pkg::RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Readies are registered copies of what the next cycle will allow
    awready_next = !aw_held_next && !bvalid_next;
    wready_next  = !w_held_next && !bvalid_next;
  end

  // Read data path; only the interrupt status has a read side effect
  always_comb begin
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (ar_take) begin
      rvalid_next = 1'b1;
      rresp_next  = is_mapped(ar_word) ? extline_pkg::RESP_OKAY
                                       : extline_pkg::RESP_SLVERR;
      rdata_next  = '0;
      case (ar_word)
        extline_pkg::OFF_RISE_CFG: begin
          rdata_next[NL-1:0] = rise_cfg_reg;
        end
        extline_pkg::OFF_FALL_CFG: begin
          rdata_next[NL-1:0] = fall_cfg_reg;
        end
        extline_pkg::OFF_SOFT_TRIG: begin
          rdata_next[NL-1:0] = soft_reg;
        end
        extline_pkg::OFF_PENDING: begin
          rdata_next[NL-1:0] = pending_reg;
        end
        extline_pkg::OFF_SEL_0_3: begin
          rdata_next = sel_0_3_reg;
        end
        extline_pkg::OFF_SEL_4_7: begin
          rdata_next = sel_4_7_reg;
        end
        extline_pkg::OFF_SEL_8: begin
          rdata_next = sel_8_reg;
        end
        extline_pkg::OFF_IRQ_STAT: begin
          rdata_next[NL-1:0] = irq_stat_reg;
        end
        extline_pkg::OFF_IRQ_MASK: begin
          rdata_next[NL-1:0] = irq_mask_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  // Line register next state
  always_comb begin
    rise_cfg_next = rise_cfg_reg;
    fall_cfg_next = fall_cfg_reg;
    soft_next     = '0;
    sel_0_3_next  = sel_0_3_reg;
    sel_4_7_next  = sel_4_7_reg;
    sel_8_next    = sel_8_reg;
    irq_mask_next = irq_mask_reg;
    pend_clr      = '0;
    fall_block    = '0;
    merged        = '0;
    if (wr_fire) begin
      case (aw_addr_reg)
        extline_pkg::OFF_RISE_CFG: begin
          merged        = merge({13'h0, rise_cfg_reg}, w_data_reg, w_strb_reg,
                                32'h0007_ffff);
          rise_cfg_next = merged[NL-1:0];
        end
        extline_pkg::OFF_FALL_CFG: begin
          merged        = merge({13'h0, fall_cfg_reg}, w_data_reg, w_strb_reg,
                                32'h0007_ffff);
          fall_cfg_next = merged[NL-1:0];
          fall_block    = '1;
        end
        extline_pkg::OFF_SOFT_TRIG: begin
          soft_next = wmask[NL-1:0];
        end
        extline_pkg::OFF_PENDING: begin
          pend_clr = wmask[NL-1:0];
        end
        extline_pkg::OFF_SEL_0_3: begin
          sel_0_3_next = merge(sel_0_3_reg, w_data_reg, w_strb_reg,
                               extline_pkg::SEL_0_3_MASK);
        end
        extline_pkg::OFF_SEL_4_7: begin
          sel_4_7_next = merge(sel_4_7_reg, w_data_reg, w_strb_reg,
                               extline_pkg::SEL_4_7_MASK);
        end
        extline_pkg::OFF_SEL_8: begin
          sel_8_next = merge(sel_8_reg, w_data_reg, w_strb_reg,
                             extline_pkg::SEL_8_MASK);
        end
        extline_pkg::OFF_IRQ_MASK: begin
          merged        = merge({13'h0, irq_mask_reg}, w_data_reg, w_strb_reg,
                                32'h0007_ffff);
          irq_mask_next = merged[NL-1:0];
        end
        default: begin
          pend_clr = '0;
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    pend_set = (line_rise & rise_cfg_reg) | (line_fall & fall_cfg_reg & ~fall_block)
               | soft_reg;
    pending_next  = (pending_reg & ~pend_clr) | pend_set;
    irq_stat_next = irq_stat_reg;
    if (ar_take && (ar_word == extline_pkg::OFF_IRQ_STAT)) begin
      irq_stat_next = '0;
    end
    irq_stat_next = irq_stat_next | pend_set;
    irq_next      = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= '0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= extline_pkg::RESP_OKAY;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= extline_pkg::RESP_OKAY;
      rdata_reg    <= '0;
      rise_cfg_reg <= extline_pkg::LINES_RESET;
      fall_cfg_reg <= extline_pkg::LINES_RESET;
      soft_reg     <= extline_pkg::LINES_RESET;
      pending_reg  <= extline_pkg::LINES_RESET;
      irq_stat_reg <= extline_pkg::LINES_RESET;
      irq_mask_reg <= extline_pkg::LINES_RESET;
      sel_0_3_reg  <= extline_pkg::SEL_RESET;
      sel_4_7_reg  <= extline_pkg::SEL_RESET;
      sel_8_reg    <= extline_pkg::SEL_RESET;
      irq_reg      <= 1'b0;
      awready_reg  <= 1'b1;
      wready_reg   <= 1'b1;
      arready_reg  <= 1'b1;
    end else begin
      aw_held_reg  <= aw_held_next;
      w_held_reg   <= w_held_next;
      aw_addr_reg  <= aw_addr_next;
      w_data_reg   <= w_data_next;
      w_strb_reg   <= w_strb_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rresp_reg    <= rresp_next;
      rdata_reg    <= rdata_next;
      rise_cfg_reg <= rise_cfg_next;
      fall_cfg_reg <= fall_cfg_next;
      soft_reg     <= soft_next;
      pending_reg  <= pending_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      sel_0_3_reg  <= sel_0_3_next;
      sel_4_7_reg  <= sel_4_7_next;
      sel_8_reg    <= sel_8_next;
      irq_reg      <= irq_next;
      awready_reg  <= awready_next;
      wready_reg   <= wready_next;
      arready_reg  <= arready_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign line_request  = pending_reg;
  assign irq           = irq_reg;
endmodule

// ### sim/extline_asserts.sv
// Port-level checks for the external line pending and port select block
module extline_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic                               aclk,
  input wire logic                               aresetn,
  input wire logic [ADDR_W-1:0]                  s_axi_awaddr,
  input wire logic                               s_axi_awvalid,
  input wire logic                               s_axi_awready,
  input wire logic [31:0]                        s_axi_wdata,
  input wire logic                               s_axi_wvalid,
  input wire logic                               s_axi_wready,
  input wire logic                               s_axi_bvalid,
  input wire logic [ADDR_W-1:0]                  s_axi_araddr,
  input wire logic                               s_axi_arvalid,
  input wire logic                               s_axi_arready,
  input wire logic [31:0]                        s_axi_rdata,
  input wire logic                               s_axi_rvalid,
  input wire logic [extline_pkg::NUM_LINES-1:0]  line_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [ADDR_W-1:0] wa_q;
  logic [ADDR_W-1:0] ra_q;
  logic [31:0]       wd_q;

  // Remember the address and data of the transfer under way
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end

  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence pend_rd;
    s_axi_rvalid && ra_q == extline_pkg::OFF_PENDING;
  endsequence
  sequence soft_wr;
    $rose(s_axi_bvalid) && wa_q == extline_pkg::OFF_SOFT_TRIG;
  endsequence

  b_after_w_a: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  r_after_ar_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
  pend_resv_a: assert property (pend_rd |-> s_axi_rdata[31:19] == 13'h0)
    else $error("pending reserved bits set");
  sel_resv_a: assert property (s_axi_rvalid && ra_q == extline_pkg::OFF_SEL_4_7 |->
    (s_axi_rdata & ~extline_pkg::SEL_4_7_MASK) == 32'h0)
    else $error("select reserved bits set");
  clr_only_w1_a: assert property ((($past(line_request) & ~line_request) != '0) |->
    $rose(s_axi_bvalid) && wa_q == extline_pkg::OFF_PENDING
    && (($past(line_request) & ~line_request & ~wd_q[18:0]) == '0))
    else $error("pending flag dropped without a one written");
  soft_sets_a: assert property (soft_wr |-> ##[0:2]
    ((line_request & wd_q[18:0]) == wd_q[18:0]))
    else $error("soft trigger did not set pending");
endmodule

bind ext_line_pending_and_port_select extline_asserts #(.ADDR_W(ADDR_W)) extline_asserts_i (.*);

// ### sim/gpio_pin_model.sv
// Behavioural pins of the three GPIO ports and the upper lines
module gpio_pin_model (
  input  wire logic       aclk,
  input  wire logic       flip,
  input  wire logic [1:0] port,
  input  wire logic [3:0] pin,
  output logic      [8:0] first_gpio_port,
  output logic      [8:0] second_gpio_port,
  output logic      [4:0] third_gpio_port,
  output logic      [9:0] upper_line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    first_gpio_port = '0;
    second_gpio_port = '0;
    third_gpio_port = '0;
    upper_line_in = '0;
  end
  // Each flip inverts one pin, so rising and falling edges alternate
  always @(posedge aclk) begin
    if (flip) begin
      case (port)
        2'h0: first_gpio_port[pin] <= !first_gpio_port[pin];
        2'h1: second_gpio_port[pin] <= !second_gpio_port[pin];
        2'h2: third_gpio_port[pin] <= !third_gpio_port[pin];
        default: upper_line_in[pin] <= !upper_line_in[pin];
      endcase
    end
  end
endmodule

// ### sim/ext_line_pending_and_port_select_test.sv
// Self-checking bench for the external line pending and port select block
module ext_line_pending_and_port_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, flip;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, t, m, c;
  logic [3:0]  s_axi_wstrb, pin;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, wrsp, port;
  logic [8:0]  first_gpio_port, second_gpio_port;
  logic [4:0]  third_gpio_port;
  logic [9:0]  upper_line_in;
  logic [18:0] line_request;
  int          n_mismatch, checks_done, exp_pend;
  int          sh [9] = '{0, 8, 16, 24, 0, 8, 16, 19, 0};
  logic [7:0]  so [3] = '{8'h60, 8'h64, 8'h68};
  logic [31:0] sm [3] = '{32'h0303_0303, 32'h0009_0103, 32'h0000_0001};

  ext_line_pending_and_port_select #(.ADDR_W(8)) ext_line_pending_and_port_select_i (.*);
  gpio_pin_model gpio_pin_model_i (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    wrsp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    rr = s_axi_rresp;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t response %h expected %h", $time, got, exp);
    end
  endtask

  task automatic flip_pin(input int p, input int n);
    @(posedge aclk);
    port <= p[1:0];
    pin <= n[3:0];
    flip <= 1'b1;
    @(posedge aclk);
    flip <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end

  initial begin
    {aresetn, flip, port, pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h6a788f91));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(so[i]);
      chk(d, 32'h0);
      wr(so[i], 32'hffff_ffff);
      rd(so[i]);
      chk(d, sm[i]);
      wr(so[i], 32'h0);
    end
    rd(extline_pkg::OFF_PENDING);
    chk(d, 32'h0);
    rd(8'h40);
    chk_resp(rr, extline_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1);
    chk_resp(wrsp, extline_pkg::RESP_SLVERR);
    wr(extline_pkg::OFF_RISE_CFG, 32'h7ffff);
    wr(extline_pkg::OFF_FALL_CFG, 32'h7ffff);
    // Each muxed line 0 to 8, each code, each port: only the chosen port's pin may reach the line
    for (int l = 0; l < 9; l++) begin
      for (int k = 0; k < ((l < 5) ? 4 : 2); k++) begin
        wr(so[(l < 4) ? 0 : (l < 8) ? 1 : 2], k << sh[l]);
        repeat (6) @(posedge aclk);
        wr(extline_pkg::OFF_PENDING, 32'h7ffff);
        exp_pend = 0;
        for (int p = 0; p < ((l < 5) ? 3 : 2); p++) begin
          flip_pin(p, l);
          if (p == k) exp_pend |= 1 << l;
          rd(extline_pkg::OFF_PENDING);
          chk(d, exp_pend);
          chk({13'h0, line_request}, exp_pend);
        end
      end
    end
    wr(extline_pkg::OFF_PENDING, 32'h7ffff);
    for (int j = 0; j < 10; j++) flip_pin(3, j);
    rd(extline_pkg::OFF_PENDING);
    chk(d, 32'h7fe00);
    wr(extline_pkg::OFF_PENDING, 32'h7ffff);
    rd(extline_pkg::OFF_IRQ_STAT);
    t = $urandom & 32'h7ffff;
    m = $urandom & 32'h7ffff;
    c = $urandom & 32'h7ffff;
    wr(extline_pkg::OFF_IRQ_MASK, m);
    wr(extline_pkg::OFF_SOFT_TRIG, t);
    rd(extline_pkg::OFF_SOFT_TRIG);
    chk(d, 32'h0);
    rd(extline_pkg::OFF_PENDING);
    chk(d, t);
    chk_resp(rr, extline_pkg::RESP_OKAY);
    chk_resp(wrsp, extline_pkg::RESP_OKAY);
    chk({31'h0, irq}, {31'h0, |(t & m)});
    wr(extline_pkg::OFF_PENDING, 32'h0);
    rd(extline_pkg::OFF_PENDING);
    chk(d, t);
    wr(extline_pkg::OFF_PENDING, c);
    rd(extline_pkg::OFF_PENDING);
    chk(d, t & ~c);
    rd(extline_pkg::OFF_IRQ_STAT);
    chk(d, t);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    summarize();
  end
endmodule
